// ===== src/ocw_defines.svh
// timing counts, command codes and field positions for the config word link
`ifndef OCW_DEFINES_SVH
`define OCW_DEFINES_SVH
`define OCW_CMD_BITS      5
`define OCW_WORD_BITS     18
`define OCW_SHORT_BITS    16
`define OCW_PULSES_PER_BIT 4
`define OCW_CMD_RD_ANGLE  5'h00
`define OCW_CMD_UNLOCK    5'h10
`define OCW_CMD_PWR_SAVE  5'h11
`define OCW_CMD_READ_WORD 5'h0f
`define OCW_CMD_SOFT_WR   5'h1f
`define OCW_CMD_BURN      5'h19
`define OCW_PASSWORD      16'h8cae
`define OCW_FACT_MSB      17
`define OCW_FACT_LSB      10
`define OCW_GAIN_MSB      9
`define OCW_GAIN_LSB      8
`define OCW_ZERO_MSB      7
`define OCW_ZERO_LSB      0
`define OCW_SCLK_HALF     8'h14
`define OCW_H_ADDR_CTRL   4'h0
`define OCW_H_ADDR_WDATA  4'h1
`define OCW_H_ADDR_STAT   4'h2
`define OCW_H_ADDR_RDATA  4'h3
`define OCW_H_ADDR_ANGLE  4'h4
`endif

// ===== src/ocw_pkg.sv
// shared types for the config word link
package ocw_pkg;
    typedef logic [17:0] ocw_word_t;
    typedef logic [4:0]  ocw_cmd_t;
    typedef logic [1:0]  ocw_gain_t;
    typedef logic [7:0]  ocw_angle_t;
endpackage : ocw_pkg

// ===== src/ocw_link_if.sv
// serial link between host and sensor: clock, chip select, data pin
interface ocw_link_if;
    logic sclk;
    logic cs;
    logic dio_host_o;
    logic dio_host_oe;
    logic dio_dev_o;
    logic dio_dev_oe;
    logic dio;
    // wired level of the shared data pin; pulled high when undriven
    assign dio = dio_host_oe ? dio_host_o : (dio_dev_oe ? dio_dev_o : 1'b1);
    modport host (output sclk, output cs, output dio_host_o,
                  output dio_host_oe, input dio);
    modport dev  (input sclk, input cs, output dio_dev_o,
                  output dio_dev_oe, input dio);
endinterface : ocw_link_if

// ===== src/ocw_sync.sv
// two-flop synchroniser with edge outputs taken from the second stage on
module ocw_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // async level in, synced level and edges out
    input  wire logic d,
    output logic      q,
    output logic      rise,
    output logic      fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    // first stage feeds only the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign q    = s2_q;
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
endmodule : ocw_sync

// ===== src/ocw_dev.sv
// sensor end: command decode, unlock, soft write and burn of config word
// Notes on behaviour
// R1: four clock pulses make one valid bit (code: only for 18-bit word data; commands and 16-bit data take one)
// R2: command 1f soft-writes the following word
// R3: command 19 burns the following word permanently
// R4: host copies factory bits into soft writes
// R5: power-up restores the burned default word
// R6: writes and burns need prior unlock
// R7: burn only sets zeros to ones
// R8: burning may repeat in several passes
// R9: host sends zero for already burned bits
// R10: host sends zero factory bits when burning
// R11: gain select codes map to four gains
// R12: zero field offsets the reported angle
// R13: same serial pins in both wiring modes
// R14: burn only on own received command
// R15: unlock needs code 10 with value 8cae
// R16: angle read or power command relocks
// R17: five bit command then 16/18 data bits
// R18: factory 17:10, gain 9:8, zero 7:0
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "ocw_defines.svh"
module ocw_dev #(
    parameter ocw_pkg::ocw_word_t FACTORY_WORD = 18'h0
) (
    // clock and reset (rst stands for power-up)
    input  wire logic           clk,
    input  wire logic           rst,
    // serial link
    ocw_link_if.dev             link,
    // wiring mode: high means two-wire, chip select ignored
    input  wire logic           two_wire,
    // raw magnet angle from the measurement path
    input  wire ocw_pkg::ocw_angle_t raw_angle,
    // user-side views of the active word, the unlock state and the burn strobe
    output ocw_pkg::ocw_word_t  active_word,
    output ocw_pkg::ocw_gain_t  gain_sel,
    output logic [7:0]          gain_x100,
    output ocw_pkg::ocw_angle_t rel_angle,
    output logic                unlocked,
    output logic                burn_pulse
);
    import ocw_pkg::*;
    typedef enum logic [3:0] {
        OCW_ST_CMD  = 4'b0001,
        OCW_ST_RX   = 4'b0010,
        OCW_ST_TX   = 4'b0100,
        OCW_ST_DONE = 4'b1000
    } ocw_dstate_e;

    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_s;
    logic        dio_s;
    ocw_dstate_e st_q;
    logic [1:0]  pulse_q;
    logic [4:0]  bit_q;
    logic [17:0] sh_q;
    ocw_cmd_t    cmd_q;
    // fuse cells start at the factory word and never see rst
    ocw_word_t   fuse_q = FACTORY_WORD;
    ocw_word_t   word_q;
    logic        load_q;
    logic        unlock_q;
    logic        burn_q;
    logic        dio_o_q;
    logic        dio_oe_q;
    ocw_gain_t   gain_q;
    logic [7:0]  gx_q;
    ocw_angle_t  rel_q;

    ocw_sync u_sclk (.clk(clk), .rst(rst), .d(link.sclk), .q(),
                     .rise(sclk_rise), .fall(sclk_fall));
    ocw_sync u_cs (.clk(clk), .rst(rst), .d(link.cs), .q(cs_s),
                   .rise(), .fall());
    ocw_sync u_dio (.clk(clk), .rst(rst), .d(link.dio), .q(dio_s),
                    .rise(), .fall());

    // frame active: cs high in three-wire, always in two-wire
    wire       frame    = two_wire | cs_s; // R13
    wire       frame_end = ~two_wire & ~cs_s;
    wire       is_word  = (cmd_q == `OCW_CMD_SOFT_WR) |
                          (cmd_q == `OCW_CMD_BURN) |
                          (cmd_q == `OCW_CMD_READ_WORD);
    // long words need four pulses per bit, commands and short data one
    wire       slow     = (st_q != OCW_ST_CMD) & is_word; // R1
    wire       bit_take = sclk_rise & frame & (~slow | (pulse_q == 2'd3));
    wire [4:0] nbits    = is_word ? 5'(`OCW_WORD_BITS)
                                  : 5'(`OCW_SHORT_BITS); // R17
    wire       last_cmd = (st_q == OCW_ST_CMD) &
                          (bit_q == 5'(`OCW_CMD_BITS - 1));
    wire       last_dat = (bit_q == nbits - 5'd1);
    wire [4:0] cmd_new  = {sh_q[3:0], dio_s};
    wire [17:0] dat_new = {sh_q[16:0], dio_s};
    wire       pw_ok    = (dat_new[15:0] == `OCW_PASSWORD); // R15
    wire       rx_end   = (st_q == OCW_ST_RX) & bit_take & last_dat;
    wire       burn_go  = rx_end & (cmd_q == `OCW_CMD_BURN) & unlock_q;

    // frame shifter and state walk
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q    <= OCW_ST_CMD;
            pulse_q <= 2'd0;
            bit_q   <= 5'd0;
            sh_q    <= 18'h0;
            cmd_q   <= 5'h0;
        end
        else if (frame_end)
        begin
            st_q    <= OCW_ST_CMD;
            pulse_q <= 2'd0;
            bit_q   <= 5'd0;
        end
        else if (sclk_rise & frame)
        begin
            pulse_q <= slow ? pulse_q + 2'd1 : 2'd0;
            if (bit_take)
            begin
                sh_q  <= dat_new;
                bit_q <= bit_q + 5'd1;
                case (st_q)
                    OCW_ST_CMD:
                    if (last_cmd)
                    begin
                        cmd_q <= cmd_new; // R17
                        bit_q <= 5'd0;
                        st_q  <= (cmd_new == `OCW_CMD_READ_WORD)
                                 ? OCW_ST_TX : OCW_ST_RX;
                    end
                    OCW_ST_RX:
                    if (last_dat)
                        st_q <= two_wire ? OCW_ST_CMD : OCW_ST_DONE;
                    OCW_ST_TX:
                    if (last_dat)
                        st_q <= two_wire ? OCW_ST_CMD : OCW_ST_DONE;
                    OCW_ST_DONE:
                        bit_q <= bit_q;
                    default:
                        st_q <= OCW_ST_CMD;
                endcase
                if (last_dat & (st_q != OCW_ST_CMD) & two_wire)
                    bit_q <= 5'd0;
            end
        end
    end

    // unlock, soft write and burn at the end of a data phase
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            word_q   <= FACTORY_WORD;
            load_q   <= 1'b1;
            unlock_q <= 1'b0;
            burn_q   <= 1'b0;
        end
        else
        begin
            burn_q <= 1'b0;
            load_q <= 1'b0;
            // power-up reload of the burned word drops soft writes
            if (load_q)
                word_q <= fuse_q; // R5
            if (rx_end)
            begin
                case (cmd_q)
                    `OCW_CMD_UNLOCK:
                        unlock_q <= pw_ok; // R15
                    `OCW_CMD_RD_ANGLE, `OCW_CMD_PWR_SAVE:
                        unlock_q <= 1'b0; // R16
                    `OCW_CMD_SOFT_WR:
                        if (unlock_q) // R6
                            word_q <= dat_new; // R2 R4
                    `OCW_CMD_BURN:
                        if (unlock_q) // R6 R14
                        begin
                            word_q <= word_q | dat_new; // R9 R10
                            burn_q <= 1'b1;
                        end
                    default:
                        unlock_q <= unlock_q;
                endcase
            end
        end
    end

    // fuse array has no reset: burned bits must outlive a power cycle
    always_ff @(posedge clk)
    begin
        if (burn_go)
            fuse_q <= fuse_q | dat_new; // R3 R7 R8
    end

    // read-out moves on falls and is released whenever no frame is active, so the host has let go of the pin
    // first and each bit still stands at its fourth fall
    wire [4:0] tx_idx = 5'(`OCW_WORD_BITS - 1) - bit_q;
    wire       tx_on  = (st_q == OCW_ST_TX) & frame;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dio_o_q  <= 1'b0;
            dio_oe_q <= 1'b0;
        end
        else if (sclk_fall | ~frame)
        begin
            dio_oe_q <= tx_on;
            dio_o_q  <= tx_on ? word_q[tx_idx] : 1'b0; // R1
        end
    end
    assign link.dio_dev_o  = dio_o_q;
    assign link.dio_dev_oe = dio_oe_q;

    // field decode: gain table and angle relative to stored zero
    wire [1:0] gsel = word_q[`OCW_GAIN_MSB:`OCW_GAIN_LSB]; // R18
    wire [7:0] zpos = word_q[`OCW_ZERO_MSB:`OCW_ZERO_LSB];
    wire [7:0] gx   = (gsel == 2'b00) ? 8'd165 :
                      (gsel == 2'b01) ? 8'd175 :
                      (gsel == 2'b10) ? 8'd186 : 8'd200; // R11
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gain_q <= 2'b00;
            gx_q   <= 8'd165;
            rel_q  <= 8'h00;
        end
        else
        begin
            gain_q <= gsel;
            gx_q   <= gx;
            rel_q  <= raw_angle - zpos; // R12
        end
    end
    assign active_word = word_q;
    assign gain_sel    = gain_q;
    assign gain_x100   = gx_q;
    assign rel_angle   = rel_q;
    assign unlocked    = unlock_q;
    assign burn_pulse  = burn_q;
endmodule : ocw_dev

// ===== src/ocw_host.sv
// host end: register port, serial clock divider, frame sender and reader
`include "ocw_defines.svh"
module ocw_host (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // register port
    input  wire logic [3:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [31:0]     rdata,
    // serial link
    ocw_link_if.host        link
);
    import ocw_pkg::*;
    typedef enum logic [2:0] {
        OCW_H_IDLE = 3'b001,
        OCW_H_RUN  = 3'b010,
        OCW_H_GAP  = 3'b100
    } ocw_hstate_e;

    ocw_hstate_e st_q;
    logic [7:0]  div_q;
    logic        sclk_q;
    logic        cs_q;
    logic        oe_q;
    logic        dout_q;
    ocw_cmd_t    cmd_q;
    logic [17:0] wd_q;
    logic [17:0] rdsh_q;
    logic [5:0]  bit_q;
    logic [1:0]  pul_q;
    logic        done_q;
    logic [31:0] rdata_q;
    logic        dio_s1_q;
    logic        dio_s2_q;

    wire       is_word = (cmd_q == `OCW_CMD_SOFT_WR) |
                         (cmd_q == `OCW_CMD_BURN) |
                         (cmd_q == `OCW_CMD_READ_WORD);
    wire [5:0] nbits   = 6'(`OCW_CMD_BITS) + (is_word ? 6'(`OCW_WORD_BITS)
                                              : 6'(`OCW_SHORT_BITS));
    wire       in_data = bit_q >= 6'(`OCW_CMD_BITS);
    wire       slow    = in_data & is_word;
    wire       half    = (div_q == `OCW_SCLK_HALF - 8'd1);
    wire       fall_ev = half & sclk_q;
    wire       bit_end = fall_ev & (~slow | (pul_q == 2'd3)); // R1
    wire       start   = wr & (addr == `OCW_H_ADDR_CTRL) & (st_q == OCW_H_IDLE);
    wire       rd_dir  = cmd_q == `OCW_CMD_READ_WORD;
    // position of the bit that goes out after the current one
    wire [5:0] nxt_pos = bit_q + 6'd1;
    wire [5:0] didx    = nbits - 6'd1 - nxt_pos;
    wire [5:0] cidx    = 6'(`OCW_CMD_BITS - 1) - nxt_pos;
    wire       nxt_bit = (nxt_pos >= 6'(`OCW_CMD_BITS)) ? wd_q[5'(didx)]
                                                        : cmd_q[3'(cidx)];

    // frame engine: cs high, clock divided, data set on falling edges
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q   <= OCW_H_IDLE;
            div_q  <= 8'h0;
            sclk_q <= 1'b0;
            cs_q   <= 1'b0;
            oe_q   <= 1'b0;
            dout_q <= 1'b0;
            bit_q  <= 6'h0;
            pul_q  <= 2'd0;
            done_q <= 1'b0;
            cmd_q  <= 5'h0;
        end
        else
        begin
            case (st_q)
                OCW_H_IDLE:
                if (start)
                begin
                    cmd_q  <= wdata[4:0]; // R6 R15 R17
                    cs_q   <= 1'b1;
                    oe_q   <= 1'b1;
                    dout_q <= wdata[4];
                    bit_q  <= 6'h0;
                    pul_q  <= 2'd0;
                    div_q  <= 8'h0;
                    done_q <= 1'b0;
                    st_q   <= OCW_H_RUN;
                end
                OCW_H_RUN:
                begin
                    div_q <= half ? 8'h0 : div_q + 8'd1;
                    if (half)
                        sclk_q <= ~sclk_q;
                    if (fall_ev)
                        pul_q <= slow ? pul_q + 2'd1 : 2'd0;
                    if (bit_end)
                    begin
                        bit_q <= bit_q + 6'd1;
                        if (bit_q == nbits - 6'd1)
                        begin
                            cs_q <= 1'b0;
                            oe_q <= 1'b0;
                            st_q <= OCW_H_GAP;
                        end
                        else
                        begin
                            dout_q <= nxt_bit;
                            oe_q   <= ~(rd_dir &
                                        (bit_q + 6'd1 >= 6'(`OCW_CMD_BITS)));
                        end
                    end
                end
                OCW_H_GAP:
                begin
                    div_q <= half ? 8'h0 : div_q + 8'd1;
                    if (half)
                    begin
                        done_q <= 1'b1;
                        st_q   <= OCW_H_IDLE;
                    end
                end
                default:
                    st_q <= OCW_H_IDLE;
            endcase
        end
    end
    // sample returned data at the fourth falling edge of each bit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dio_s1_q <= 1'b1;
            dio_s2_q <= 1'b1;
            rdsh_q   <= 18'h0;
            wd_q     <= 18'h0;
        end
        else
        begin
            dio_s1_q <= link.dio;
            dio_s2_q <= dio_s1_q;
            if (wr & (addr == `OCW_H_ADDR_WDATA))
                wd_q <= wdata[17:0]; // R4 R9 R10
            if (fall_ev & slow & rd_dir & (pul_q == 2'd3))
                rdsh_q <= {rdsh_q[16:0], dio_s2_q}; // R1
        end
    end

    // register read port, data one cycle after strobe
    wire [31:0] rmux =
        (addr == `OCW_H_ADDR_WDATA) ? {14'h0, wd_q} :
        (addr == `OCW_H_ADDR_STAT)  ? {30'h0, done_q, st_q != OCW_H_IDLE} :
        (addr == `OCW_H_ADDR_RDATA) ? {14'h0, rdsh_q} :
        (addr == `OCW_H_ADDR_CTRL)  ? {27'h0, cmd_q} : 32'h0;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_q <= 32'h0;
        else
            rdata_q <= rd ? rmux : 32'h0;
    end
    assign rdata            = rdata_q;
    assign link.sclk        = sclk_q;
    assign link.cs          = cs_q;
    assign link.dio_host_o  = dout_q;
    assign link.dio_host_oe = oe_q;
endmodule : ocw_host

// ===== verification/ocw_link_chk.sv
// wire-level checks on the link between the host and sensor ends
module ocw_link_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link signals
    input wire logic sclk,
    input wire logic cs,
    input wire logic dio_host_o,
    input wire logic dio_host_oe,
    input wire logic dio_dev_oe
);
    logic       sclk_q;
    logic       cs_q;
    logic [7:0] per_q;
    logic [7:0] rises_q;
    wire        rise_ev = sclk && !sclk_q;
    wire        cs_rise = cs && !cs_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // cycles since the last rise, rises seen in the current frame
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sclk_q  <= 1'b0;
            cs_q    <= 1'b0;
            per_q   <= 8'h00;
            rises_q <= 8'h00;
        end
        else
        begin
            sclk_q  <= sclk;
            cs_q    <= cs;
            per_q   <= rise_ev ? 8'h01 :
                       (cs_rise || per_q == 8'h00) ? 8'h00 : per_q + 8'h01;
            rises_q <= cs_rise ? 8'h00 : rises_q + {7'h00, rise_ev};
        end
    end

    sequence s_hold_high;
        sclk ##19 sclk ##1 !sclk;
    endsequence

    property p_no_clash;
        !(dio_host_oe && dio_dev_oe);
    endproperty
    property p_sclk_in_frame;
        $rose(sclk) |-> cs;
    endproperty
    property p_frame_opens_low;
        $rose(cs) |-> !sclk;
    endproperty
    property p_high_phase;
        $rose(sclk) |-> s_hold_high;
    endproperty
    property p_period;
        rise_ev && per_q != 8'h00 |-> per_q == 8'h28;
    endproperty
    property p_host_data_low;
        dio_host_oe && $past(dio_host_oe) && $changed(dio_host_o) |-> !sclk;
    endproperty
    // a frame is 5 command pulses plus 16 single or 18 quadruple bits
    property p_pulse_count;
        !cs && cs_q |-> rises_q == 8'h15 || rises_q == 8'h4d;
    endproperty
    property p_dev_in_frame;
        $rose(dio_dev_oe) |-> cs;
    endproperty
    property p_after_reset;
        $fell(rst) |-> !cs && !sclk && !dio_host_oe && !dio_dev_oe;
    endproperty

    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive the data pin");
    a_sclk_in_frame: assert property (p_sclk_in_frame)
        else $error("serial clock rose outside a frame");
    a_frame_opens_low: assert property (p_frame_opens_low)
        else $error("frame opened with serial clock high");
    a_high_phase: assert property (p_high_phase)
        else $error("serial clock high phase not 20 cycles");
    a_period: assert property (p_period)
        else $error("serial clock period not 40 cycles");
    a_host_data_low: assert property (p_host_data_low)
        else $error("host data moved while serial clock high");
    a_pulse_count: assert property (p_pulse_count)
        else $error("wrong count of clock pulses in frame");
    a_dev_in_frame: assert property (p_dev_in_frame)
        else $error("sensor drove data outside a frame");
    a_after_reset: assert property (p_after_reset)
        else $error("link not quiet after reset");
endmodule : ocw_link_chk

// ===== verification/otp_config_write_path_tb.sv
// bench: host and sensor ends joined by the link, driven via registers
module otp_config_write_path_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ocw_pkg::*;
    // factory bits set, user fields clear; last soft word of t_soft
    localparam ocw_word_t  FACT = 18'h15400;
    localparam ocw_word_t  LAST = FACT | 18'h003c3;
    localparam logic [7:0] GAINS [4] = '{8'ha5, 8'haf, 8'hba, 8'hc8};
    logic        clk, rst, wr, rd, two_wire;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata;
    ocw_angle_t  raw_angle, rel_angle;
    ocw_word_t   active_word;
    ocw_gain_t   gain_sel;
    logic [7:0]  gain_x100;
    logic        unlocked, burn_pulse;
    int          num_errors, checked, burns;

    ocw_link_if i_ocw_link_if ();
    ocw_host i_ocw_host (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .link(i_ocw_link_if.host));
    ocw_dev #(.FACTORY_WORD(FACT)) i_ocw_dev (.clk(clk), .rst(rst),
        .link(i_ocw_link_if.dev), .two_wire(two_wire),
        .raw_angle(raw_angle), .active_word(active_word),
        .gain_sel(gain_sel), .gain_x100(gain_x100), .rel_angle(rel_angle),
        .unlocked(unlocked), .burn_pulse(burn_pulse));
    ocw_link_chk i_ocw_link_chk (.clk(clk), .rst(rst),
        .sclk(i_ocw_link_if.sclk), .cs(i_ocw_link_if.cs),
        .dio_host_o(i_ocw_link_if.dio_host_o),
        .dio_host_oe(i_ocw_link_if.dio_host_oe),
        .dio_dev_oe(i_ocw_link_if.dio_dev_oe));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // burns applied, counted so a stray burn cannot hide
    always @(posedge clk)
        if (burn_pulse === 1'b1)
            burns++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg

    // one link frame: data, command, wait for done and not busy
    task automatic frame(input logic [4:0] cmd, input logic [17:0] data);
        logic [31:0] s;
        s = '0;
        wreg(4'h1, {14'h0, data});
        wreg(4'h0, {27'h0, cmd});
        for (int i = 0; i < 2000 && s[1:0] !== 2'b10; i++)
            rreg(4'h2, s);
        chk(s[1:0], 2'b10);
        repeat (8) @(posedge clk);
    endtask : frame

    task automatic power_cycle();
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // live word reloads from the fuses one cycle after release
        repeat (2) @(posedge clk);
    endtask : power_cycle

    task automatic t_locked();
        chk(active_word, FACT);
        chk(unlocked, 1'b0);
        frame(5'h1f, FACT | 18'h003ff);
        chk(active_word, FACT);
        frame(5'h10, 18'h08cad);
        chk(unlocked, 1'b0);
        frame(5'h10, 18'h08cae);
        chk(unlocked, 1'b1);
        frame(5'h10, 18'h00000);
        chk(unlocked, 1'b0);
    endtask : t_locked

    // every gain code, zero field taken off the raw angle with wrap
    task automatic t_soft();
        logic [31:0] rb;
        ocw_word_t   w;
        frame(5'h0f, 18'h0);
        rreg(4'h3, rb);
        chk(rb[17:0], FACT);
        frame(5'h10, 18'h08cae);
        for (int g = 0; g < 4; g++)
        begin
            w = {rb[17:10], g[1:0], 8'hc0 + 8'(g)};
            raw_angle <= 8'h10 + 8'(g);
            frame(5'h1f, w);
            chk(active_word, w);
            chk(gain_sel, g[1:0]);
            chk(gain_x100, GAINS[g]);
            chk(rel_angle, 8'h50);
        end
        frame(5'h0f, 18'h0);
        rreg(4'h3, rb);
        chk(rb[17:0], LAST);
        chk(burns, 0);
    endtask : t_soft

    task automatic t_relock();
        logic [4:0] cmds [2] = '{5'h00, 5'h11};
        for (int i = 0; i < 2; i++)
        begin
            frame(5'h10, 18'h08cae);
            frame(cmds[i], 18'h0);
            chk(unlocked, 1'b0);
            frame(5'h1f, FACT);
            chk(active_word, LAST);
        end
    endtask : t_relock

    task automatic t_two_wire();
        two_wire <= 1'b1;
        frame(5'h10, 18'h08cae);
        frame(5'h1f, FACT | 18'h00155);
        chk(active_word, FACT | 18'h00155);
        two_wire <= 1'b0;
        power_cycle();
        chk(active_word, FACT);
    endtask : t_two_wire

    // factory bits sent as zero, burned bits sent as zero later
    task automatic t_burn();
        int b;
        frame(5'h10, 18'h08cae);
        frame(5'h19, 18'h00103);
        chk(active_word, FACT | 18'h00103);
        chk(burns, 1);
        frame(5'h19, 18'h00030);
        chk(active_word, FACT | 18'h00133);
        frame(5'h19, 18'h00000);
        chk(active_word, FACT | 18'h00133);
        power_cycle();
        chk(active_word, FACT | 18'h00133);
        b = burns;
        frame(5'h19, 18'h00008);
        chk(active_word, FACT | 18'h00133);
        chk(burns, b);
    endtask : t_burn

    task automatic results();
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    initial
    begin
        #380000;
        num_errors++;
        results();
    end

    initial
    begin
        rst       = 1'b1;
        wr        = 1'b0;
        rd        = 1'b0;
        addr      = 4'h0;
        wdata     = 32'h0;
        two_wire  = 1'b0;
        raw_angle = 8'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_locked();
        t_soft();
        t_relock();
        t_two_wire();
        t_burn();
        results();
    end
endmodule : otp_config_write_path_tb
